/* dv/e1rs_framer_model.sv */
// Far-end framer model: turns level settings into periodic receive strobes
`timescale 1ns/10ps
module e1rs_framer_model
	import e1rs_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Level settings from the bench
	input wire e1rs_rx_s ctl_i,
	// Status as the receive framer would present it
	output e1rs_rx_s rx_o
);
	// ==========================================================
	// Frame counter, wraps every 100 cycles
	logic [6:0] cnt_q;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i || cnt_q == 7'h63) begin
			cnt_q <= 7'h00;
		end else begin
			cnt_q <= cnt_q + 7'h01;
		end
	end

	// ==========================================================
	// Strobes: alignment word at counts 3, 35, 67 and 99, E-bits every 100, CRC sync every 100 only while CRC-4 multiframe is held
	always_comb begin
		rx_o = ctl_i;
		rx_o.fas_strobe = (cnt_q[4:0] == 5'h03);
		rx_o.ebit_strobe = (cnt_q == 7'h32);
		rx_o.crc4_submf_pulse = !ctl_i.crc4_multiframe_loss && (cnt_q == 7'h00);
	end
endmodule

/* dv/tb_e1rs_status_bank.sv */
// Self-checking bench of the receive status bank
`timescale 1ns/10ps
module tb_e1rs_status_bank
	import e1rs_pkg::*;
;
	// ==========================================================
	// Signals
	localparam int MS = 40;
	localparam int LIMIT = 90000;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic cs_n_i = 1'b1;
	logic rd_n_i = 1'b1;
	logic wr_n_i = 1'b1;
	logic [4:0] addr_i = 5'h00;
	logic [7:0] data_i = 8'h00;
	logic [7:0] page_i = PAGE_STATUS;
	e1rs_rx_s ctl = '0;
	e1rs_rx_s rx;
	e1rs_words_s words_i = '0;
	logic [7:0] data_o;
	logic data_oe_o;
	logic reframe_o;
	logic oe_seen = 1'b0;
	logic [15:0] ent;
	logic [15:0] exp_q[$];
	int bad_count = 0, total_checks = 0, cyc = 0, rf_count = 0, rf_first = 0;
	int f7 = 0, f6 = 0, lone6 = 0, f3 = 0, f2 = 0, f1a = 0, f1b = 0, t7 = 0;
	int seed = 32'hfe14_3746;

	e1rs_framer_model u_far (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ctl_i(ctl), .rx_o(rx));

	e1rs_status_bank #(.MS_CYCLES(MS)) DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .addr_i(addr_i), .data_i(data_i),
		.data_o(data_o), .data_oe_o(data_oe_o), .page_i(page_i), .rx_i(rx),
		.words_i(words_i), .reframe_o(reframe_o));

	initial begin
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	// ==========================================================
	// Tasks
	task automatic final_report();
		$display("checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
		total_checks++;
		if ((got & msk) !== (exp & msk)) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got & msk, exp & msk);
		end
	endtask

	task automatic rng(input int v, input int lo, input int hi);
		chk(8'(v >= lo && v <= hi), 8'h01, 8'hff);
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#2;
	endtask

	// Read cycle: on the status page the expected word goes to the queue for the monitor; on other pages data_oe_o must stay low
	task automatic rd(input logic [4:0] a, input logic [7:0] exp, input logic [7:0] msk);
		if (page_i === PAGE_STATUS) exp_q.push_back({exp, msk});
		cs_n_i = 1'b0;
		rd_n_i = 1'b0;
		addr_i = a;
		step(4);
		if (page_i !== PAGE_STATUS) chk({7'h00, data_oe_o}, 8'h00, 8'h01);
		cs_n_i = 1'b1;
		rd_n_i = 1'b1;
		step(4);
	endtask

	task automatic wr(input logic [4:0] a);
		cs_n_i = 1'b0;
		wr_n_i = 1'b0;
		addr_i = a;
		data_i = 8'($random(seed));
		step(4);
		cs_n_i = 1'b1;
		wr_n_i = 1'b1;
		step(4);
	endtask

	// ==========================================================
	// Monitor: compares each answer with the oldest note, watches reframe and hangs
	always @(negedge clk_sys_i) begin
		cyc++;
		if (reframe_o === 1'b1) begin
			rf_count++;
			if (rf_first == 0) rf_first = cyc;
		end
		if (data_oe_o === 1'b1 && oe_seen !== 1'b1) begin
			if (exp_q.size() > 0) begin
				ent = exp_q.pop_front();
				chk(data_o, ent[15:8], ent[7:0]);
			end else begin
				chk(8'h00, 8'hff, 8'hff);
			end
		end
		oe_seen <= data_oe_o;
		if (cyc == LIMIT) begin
			bad_count++;
			final_report();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		int i;
		int k;
		int t0;
		logic [7:0] v;
		logic [7:0] prev;
		logic [7:0] b;
		words_i = {$random(seed), $random(seed)};
		step(6);
		rst_i = 1'b0;
		rd(OFS_SYNC, RST_BYTE, 8'hfe);
		rd(OFS_TIMER, RST_BYTE, 8'hfd);
		wr(OFS_SYNC);
		wr(OFS_FAS);
		wr(OFS_IDENT);
		rd(OFS_SYNC, RST_BYTE, 8'hfe);
		rd(OFS_FAS, 8'h00, 8'hff);
		rd(OFS_IDENT, IDENT_VALUE, 8'hff);
		for (i = 27; i <= 30; i++) rd(5'(i), UNUSED_READ, 8'hff);
		rd(5'h05, UNUSED_READ, 8'hff);
		page_i = 8'h02;
		rd(OFS_IDENT, 8'h00, 8'h00);
		page_i = PAGE_STATUS;
		for (i = 0; i < 8; i++) rd(OFS_NFAS + 5'(i), words_i[63 - 8 * i -: 8], 8'hff);
		$display("test map done");
		for (k = 0; k < 8; k++) begin
			{ctl.basic_frame_loss, ctl.sig_multiframe_loss, ctl.crc4_multiframe_loss} = 3'(k);
			rd(OFS_SYNC, {3'(k), 5'h00}, 8'he0);
		end
		ctl.basic_frame_loss = 1'b0;
		ctl.sig_multiframe_loss = 1'b0;
		ctl.crc4_multiframe_loss = 1'b0;
		for (k = 0; k < 4; k++) begin
			{ctl.rx_ebit_first, ctl.rx_ebit_second} = 2'(k);
			step(110);
			rd(OFS_SYNC, {3'h0, 2'(k), 3'h0}, 8'h18);
		end
		for (k = 0; k < 4; k++) begin
			ctl.fas_byte = (k == 0) ? {1'b1, FAS_PATTERN} : 8'($random(seed));
			step(40);
			rd(OFS_FAS, ctl.fas_byte, 8'hff);
		end
		rd(OFS_SYNC, 8'h01, 8'h01);
		$display("test sync done");
		ctl.basic_frame_loss = 1'b1;
		ctl.all_ones_alarm_status = 1'b1;
		ctl.nonnormal_frames = 1'b1;
		step(90 * MS);
		rd(OFS_SYNC, 8'h00, 8'h02);
		rd(OFS_TIMER, 8'h00, 8'h21);
		step(20 * MS);
		rd(OFS_SYNC, 8'h02, 8'h02);
		rd(OFS_TIMER, 8'h21, 8'h21);
		ctl.basic_frame_loss = 1'b0;
		rd(OFS_SYNC, 8'h00, 8'h02);
		ctl.all_ones_alarm_status = 1'b0;
		rd(OFS_TIMER, 8'h00, 8'h01);
		ctl.nonnormal_frames = 1'b0;
		ctl.terminal_sync = 1'b1;
		step(8 * MS);
		rd(OFS_TIMER, 8'h20, 8'h30);
		step(4 * MS);
		rd(OFS_TIMER, 8'h10, 8'h30);
		ctl.nonnormal_frames = 1'b1;
		rd(OFS_TIMER, 8'h00, 8'h10);
		ctl.nonnormal_frames = 1'b0;
		ctl.terminal_sync = 1'b0;
		ctl.basic_frame_loss = 1'b1;
		ctl.all_ones_alarm_status = 1'b1;
		step(110 * MS);
		rd(OFS_SYNC, 8'h02, 8'h02);
		rst_i = 1'b1;
		step(6);
		rst_i = 1'b0;
		rd(OFS_SYNC, 8'h80, 8'hfe);
		rd(OFS_TIMER, RST_BYTE, 8'hfd);
		ctl.basic_frame_loss = 1'b0;
		ctl.all_ones_alarm_status = 1'b0;
		$display("test alarms done");
		ctl.maint_option = 1'b1;
		ctl.crc4_multiframe_loss = 1'b1;
		rf_first = 0;
		t0 = cyc;
		step(12 * MS);
		rng(rf_first - t0, 7 * MS, 10 * MS);
		rd(OFS_SYNC, 8'h04, 8'h04);
		ctl.auto_interwork = 1'b1;
		ctl.crc4_multiframe_loss = 1'b0;
		step(2);
		ctl.crc4_multiframe_loss = 1'b1;
		rf_count = 0;
		step(12 * MS);
		rng(rf_count, 0, 0);
		rd(OFS_SYNC, 8'h04, 8'h04);
		ctl.maint_option = 1'b0;
		ctl.auto_interwork = 1'b0;
		ctl.crc4_multiframe_loss = 1'b0;
		$display("test hunt done");
		exp_q.push_back(16'h0000);
		cs_n_i = 1'b0;
		rd_n_i = 1'b0;
		addr_i = OFS_TIMER;
		step(4);
		prev = data_o;
		for (i = 0; i < 42000; i++) begin
			if (i == 1000) ctl.crc4_multiframe_loss = 1'b1;
			step(1);
			v = data_o;
			b = v ^ prev;
			if (b[TMR_HALF_BIT]) begin
				if (f7 == 1) t7 = i - t7;
				if (f7 == 0) t7 = i;
				f7++;
			end
			if (b[TMR_ONE_BIT]) f6++;
			if (b[TMR_ONE_BIT] && !b[TMR_HALF_BIT]) lone6++;
			f3 += b[TMR_LONG_BIT];
			f2 += b[TMR_SHORT_BIT];
			if (i < 1000) f1a += b[TMR_ALIGN_BIT];
			if (i >= 1000 && i < 2000) f1b += b[TMR_ALIGN_BIT];
			prev = v;
		end
		cs_n_i = 1'b1;
		rd_n_i = 1'b1;
		step(4);
		rng(f7, 2, 3);
		rng(t7, 500 * MS - 2, 500 * MS + 2);
		rng(f6, 1, 2);
		rng(lone6, 0, 0);
		rng(f3, 1, 3);
		rng(f2, 1, 200);
		rng(f1a, 9, 11);
		rng(f1b, 24, 26);
		rd(OFS_SYNC, 8'h00, 8'h01);
		ctl.crc4_multiframe_loss = 1'b0;
		$display("test timers done");
		final_report();
	end
endmodule

/* rtl/e1rs_pkg.sv */
// Package: register map, field positions, timing constants and carriers of the status bank
package e1rs_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] PAGE_STATUS = 8'h03;
	localparam logic [4:0] OFS_SYNC = 5'h10;
	localparam logic [4:0] OFS_FAS = 5'h11;
	localparam logic [4:0] OFS_TIMER = 5'h12;
	localparam logic [4:0] OFS_NFAS = 5'h13;
	localparam logic [4:0] OFS_MFAS = 5'h14;
	localparam logic [4:0] OFS_PHASE_HI = 5'h15;
	localparam logic [4:0] OFS_PHASE_LO = 5'h16;
	localparam logic [4:0] OFS_JITTER = 5'h17;
	localparam logic [4:0] OFS_SIGNAL = 5'h18;
	localparam logic [4:0] OFS_ALARM1 = 5'h19;
	localparam logic [4:0] OFS_SPARE = 5'h1a;
	localparam logic [4:0] OFS_IDENT = 5'h1f;
	// Identification value is arbitrary
	localparam logic [7:0] IDENT_VALUE = 8'h5c;
	localparam logic [7:0] UNUSED_READ = 8'h00;

	// ==========================================================
	// Field positions
	localparam int SYNC_BASIC_BIT = 7;
	localparam int SYNC_SIGMF_BIT = 6;
	localparam int SYNC_CRCMF_BIT = 5;
	localparam int SYNC_EBIT1_BIT = 4;
	localparam int SYNC_EBIT2_BIT = 3;
	localparam int SYNC_TOUT_BIT = 2;
	localparam int SYNC_RED_BIT = 1;
	localparam int SYNC_IWK_BIT = 0;
	localparam int TMR_HALF_BIT = 7;
	localparam int TMR_ONE_BIT = 6;
	localparam int TMR_NONNORM_BIT = 5;
	localparam int TMR_TERM_BIT = 4;
	localparam int TMR_LONG_BIT = 3;
	localparam int TMR_SHORT_BIT = 2;
	localparam int TMR_ALIGN_BIT = 1;
	localparam int TMR_KEEP_BIT = 0;
	localparam logic [6:0] FAS_PATTERN = 7'h1b;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic RST_LOSS = 1'b1;
	localparam logic RST_INTERWORK = 1'b0;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
	localparam int unsigned HALF_SEC_MS = 500;
	localparam int unsigned RED_MS = 100;
	localparam int unsigned NONNORM_MS = 100;
	localparam int unsigned TERM_SYNC_MS = 10;
	localparam int unsigned CRC_SHORT_MS = 8;
	localparam int unsigned CRC_LONG_MS = 400;
	localparam int unsigned KEEP_ALIVE_MS = 100;

	typedef logic [8:0] e1rs_ms_t;

	// ==========================================================
	// Status carried in from the receive framer (same clock)
	typedef struct packed {
		logic basic_frame_loss;
		logic sig_multiframe_loss;
		logic crc4_multiframe_loss;
		logic crc4_submf_pulse;
		logic ebit_strobe;
		logic rx_ebit_first;
		logic rx_ebit_second;
		logic fas_strobe;
		logic [7:0] fas_byte;
		logic nonnormal_frames;
		logic terminal_sync;
		logic all_ones_alarm_status;
		logic maint_option;
		logic auto_interwork;
	} e1rs_rx_s;

	// Status words owned by neighbouring blocks
	typedef struct packed {
		logic [7:0] nfas;
		logic [7:0] mfas;
		logic [7:0] phase_hi;
		logic [7:0] phase_lo;
		logic [7:0] jitter;
		logic [7:0] signal;
		logic [7:0] alarm1;
		logic [7:0] spare;
	} e1rs_words_s;

endpackage

/* rtl/e1rs_status_bank.sv */
// Receive synchronisation, frame alignment and timer status bank with its host read port
`timescale 1ns/10ps

// Operation
// - bit 7 reports basic frame alignment loss
// - bit 6 reports signalling multiframe alignment loss
// - bit 5 reports CRC-4 multiframe alignment loss
// - bits 4,3 hold last received E-bits
// - bit 2 sets on 8 ms CRC-4 search timeout
// - timeout forces reframe in maintenance, no interworking
// - red alarm after 100 ms loss, clears on alignment
// - bit 0 shows CRC-4 interworking state
// - frame alignment register bit 7 captures first bit
// - bits 6..0 capture alignment pattern bits
// - half-second toggle flips every 0.5 s
// - one-second toggle flips every second, in step
// - non-normal flag after 100 ms, cleared by terminal flag
// - terminal flag after 10 ms sync, cleared by non-normal
// - long toggle flips on 400 ms timer expiry
// - short toggle flips on 8 ms timer expiry
// - alignment toggle every ms, CRC-locked once aligned
// - keep-alive after 100 ms all-ones, clears when low
// - page 03H decodes 10H-1AH and 1FH only
module e1rs_status_bank
	import e1rs_pkg::*;
#(
	parameter int unsigned MS_CYCLES = TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Host parallel port pins
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [4:0] addr_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_o,
	// Page selection from the page register
	input wire logic [7:0] page_i,
	// Receive framer status
	input wire e1rs_rx_s rx_i,
	input wire e1rs_words_s words_i,
	// Reframe request to the framer
	output logic reframe_o
);
	// ==========================================================
	// Pin synchronisers
	logic [7:0] pin_meta_q;
	logic [7:0] pin_sync_q;
	logic [7:0] wdata_meta_q;
	logic [7:0] wdata_q;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pin_meta_q <= 8'hff;
			pin_sync_q <= 8'hff;
			wdata_meta_q <= 8'h00;
			wdata_q <= 8'h00;
		end else begin
			pin_meta_q <= {cs_n_i, rd_n_i, wr_n_i, addr_i};
			pin_sync_q <= pin_meta_q;
			wdata_meta_q <= data_i;
			wdata_q <= wdata_meta_q;
		end
	end

	// ==========================================================
	// Millisecond enable
	logic ms_tick;

	e1rs_tick_div #(
		.CYCLES(MS_CYCLES)
	) u_ms_div (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.tick_o(ms_tick)
	);

	// Persistence count: clears when the condition drops, saturates at the limit
	function automatic e1rs_ms_t persist(input e1rs_ms_t cnt, input logic cond,
		input logic tick, input int unsigned limit);
		e1rs_ms_t res;
		res = cnt;
		if (!cond) begin
			res = 9'h000;
		end else if (tick && (cnt < 9'(limit))) begin
			res = cnt + 9'h001;
		end
		return res;
	endfunction

	// ==========================================================
	// Free-running second timers
	e1rs_ms_t half_cnt_q;
	logic half_second_toggle_q;
	logic one_second_toggle_q;
	logic half_wrap;

	assign half_wrap = ms_tick && (half_cnt_q == 9'(HALF_SEC_MS - 1));

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			half_cnt_q <= 9'h000;
			half_second_toggle_q <= 1'b0;
			one_second_toggle_q <= 1'b0;
		end else begin
			if (ms_tick) begin
				half_cnt_q <= half_wrap ? 9'h000 : half_cnt_q + 9'h001;
			end
			if (half_wrap) begin
				half_second_toggle_q <= ~half_second_toggle_q;
				// One-second bit flips on every other half-second edge
				if (half_second_toggle_q) begin
					one_second_toggle_q <= ~one_second_toggle_q;
				end
			end
		end
	end

	// ==========================================================
	// Alignment status, red alarm, E-bits, frame alignment capture
	e1rs_ms_t red_cnt_q;
	logic red_alarm_q;
	logic rx_ebit_first_q;
	logic rx_ebit_second_q;
	logic [7:0] fas_q;
	logic basic_aligned;

	assign basic_aligned = ~rx_i.basic_frame_loss;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			red_cnt_q <= 9'h000;
			red_alarm_q <= 1'b0;
			rx_ebit_first_q <= 1'b0;
			rx_ebit_second_q <= 1'b0;
			fas_q <= RST_BYTE;
		end else begin
			red_cnt_q <= persist(red_cnt_q, rx_i.basic_frame_loss, ms_tick, RED_MS);
			if (basic_aligned) begin
				red_alarm_q <= 1'b0;
			end else if (red_cnt_q >= 9'(RED_MS)) begin
				red_alarm_q <= 1'b1;
			end
			if (rx_i.ebit_strobe) begin
				rx_ebit_first_q <= rx_i.rx_ebit_first;
				rx_ebit_second_q <= rx_i.rx_ebit_second;
			end
			if (rx_i.fas_strobe) begin
				fas_q <= rx_i.fas_byte;
			end
		end
	end

	// ==========================================================
	// CRC-4 multiframe search timers and interworking
	e1rs_ms_t short_cnt_q;
	e1rs_ms_t long_cnt_q;
	logic crc4_search_timeout_q;
	logic short_crc_timer_toggle_q;
	logic long_crc_timer_toggle_q;
	logic crc4_interwork_state_q;
	logic reframe_q;
	logic crc_hunt;
	logic short_expire;
	logic long_expire;

	// Timers run only while basic frame is held and CRC-4 is still sought
	assign crc_hunt = basic_aligned && rx_i.crc4_multiframe_loss;
	assign short_expire = crc_hunt && ms_tick && !crc4_search_timeout_q
		&& (short_cnt_q == 9'(CRC_SHORT_MS - 1));
	assign long_expire = crc_hunt && ms_tick && (long_cnt_q == 9'(CRC_LONG_MS - 1));

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			short_cnt_q <= 9'h000;
			long_cnt_q <= 9'h000;
			crc4_search_timeout_q <= 1'b0;
			short_crc_timer_toggle_q <= 1'b0;
			long_crc_timer_toggle_q <= 1'b0;
			crc4_interwork_state_q <= RST_INTERWORK;
			reframe_q <= 1'b0;
		end else begin
			short_cnt_q <= persist(short_cnt_q, crc_hunt, ms_tick, CRC_SHORT_MS);
			long_cnt_q <= persist(long_cnt_q, crc_hunt, ms_tick, CRC_LONG_MS);
			if (short_expire) begin
				crc4_search_timeout_q <= 1'b1;
				short_crc_timer_toggle_q <= ~short_crc_timer_toggle_q;
			end else if (!crc_hunt) begin
				crc4_search_timeout_q <= 1'b0;
			end
			if (long_expire) begin
				long_crc_timer_toggle_q <= ~long_crc_timer_toggle_q;
				crc4_interwork_state_q <= 1'b0;
			end else if (basic_aligned && !rx_i.crc4_multiframe_loss) begin
				crc4_interwork_state_q <= 1'b1;
			end
			// One-cycle request for a new basic frame search
			reframe_q <= short_expire && rx_i.maint_option && !rx_i.auto_interwork;
		end
	end

	// ==========================================================
	// Alignment millisecond toggle
	logic crc_align_ms_toggle_q;
	logic align_flip;

	assign align_flip = rx_i.crc4_multiframe_loss ? ms_tick : rx_i.crc4_submf_pulse;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			crc_align_ms_toggle_q <= 1'b0;
		end else if (align_flip) begin
			crc_align_ms_toggle_q <= ~crc_align_ms_toggle_q;
		end
	end

	// ==========================================================
	// Persistence flags for line condition and keep-alive
	e1rs_ms_t nonnorm_cnt_q;
	e1rs_ms_t term_cnt_q;
	e1rs_ms_t keep_cnt_q;
	logic nonnormal_persist_flag_q;
	logic terminal_sync_persist_flag_q;
	logic keep_alive_flag_q;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			nonnorm_cnt_q <= 9'h000;
			term_cnt_q <= 9'h000;
			keep_cnt_q <= 9'h000;
			nonnormal_persist_flag_q <= 1'b0;
			terminal_sync_persist_flag_q <= 1'b0;
			keep_alive_flag_q <= 1'b0;
		end else begin
			nonnorm_cnt_q <= persist(nonnorm_cnt_q, rx_i.nonnormal_frames, ms_tick, NONNORM_MS);
			term_cnt_q <= persist(term_cnt_q, rx_i.terminal_sync, ms_tick, TERM_SYNC_MS);
			keep_cnt_q <= persist(keep_cnt_q, rx_i.all_ones_alarm_status, ms_tick,
				KEEP_ALIVE_MS);
			if (rx_i.nonnormal_frames) begin
				terminal_sync_persist_flag_q <= 1'b0;
			end else if (term_cnt_q >= 9'(TERM_SYNC_MS)) begin
				terminal_sync_persist_flag_q <= 1'b1;
			end
			if (terminal_sync_persist_flag_q) begin
				nonnormal_persist_flag_q <= 1'b0;
			end else if (nonnorm_cnt_q >= 9'(NONNORM_MS)) begin
				nonnormal_persist_flag_q <= 1'b1;
			end
			if (!rx_i.all_ones_alarm_status) begin
				keep_alive_flag_q <= 1'b0;
			end else if (keep_cnt_q >= 9'(KEEP_ALIVE_MS)) begin
				keep_alive_flag_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Status words and read decode
	logic [7:0] sync_word;
	logic [7:0] timer_word;
	logic [7:0] read_mux;
	logic rd_act;
	logic page_hit;
	logic [4:0] rd_addr;

	assign sync_word = {rx_i.basic_frame_loss, rx_i.sig_multiframe_loss,
		rx_i.crc4_multiframe_loss, rx_ebit_first_q, rx_ebit_second_q,
		crc4_search_timeout_q, red_alarm_q, crc4_interwork_state_q};
	assign timer_word = {half_second_toggle_q, one_second_toggle_q,
		nonnormal_persist_flag_q, terminal_sync_persist_flag_q,
		long_crc_timer_toggle_q, short_crc_timer_toggle_q,
		crc_align_ms_toggle_q, keep_alive_flag_q};
	assign rd_addr = pin_sync_q[4:0];
	// A write strobe never enables the bus; write data is dropped
	assign rd_act = !pin_sync_q[7] && !pin_sync_q[6] && pin_sync_q[5];
	assign page_hit = (page_i == PAGE_STATUS);

	always_comb begin
		read_mux = UNUSED_READ;
		if (page_hit) begin
			case (rd_addr)
				OFS_SYNC: read_mux = sync_word;
				OFS_FAS: read_mux = fas_q;
				OFS_TIMER: read_mux = timer_word;
				OFS_NFAS: read_mux = words_i.nfas;
				OFS_MFAS: read_mux = words_i.mfas;
				OFS_PHASE_HI: read_mux = words_i.phase_hi;
				OFS_PHASE_LO: read_mux = words_i.phase_lo;
				OFS_JITTER: read_mux = words_i.jitter;
				OFS_SIGNAL: read_mux = words_i.signal;
				OFS_ALARM1: read_mux = words_i.alarm1;
				OFS_SPARE: read_mux = words_i.spare;
				OFS_IDENT: read_mux = IDENT_VALUE;
				default: read_mux = UNUSED_READ;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			data_o <= RST_BYTE;
			data_oe_o <= 1'b0;
		end else begin
			data_o <= rd_act ? read_mux : RST_BYTE;
			data_oe_o <= rd_act && page_hit;
		end
	end

	assign reframe_o = reframe_q;

	// ==========================================================
	// Checks
	property p_red_clear;
		@(posedge clk_sys_i) disable iff (rst_i)
		basic_aligned |=> !red_alarm_q;
	endproperty
	a_red_clear: assert property (p_red_clear) else $error("red alarm held while aligned");

	property p_red_set;
		@(posedge clk_sys_i) disable iff (rst_i)
		$rose(red_alarm_q) |-> $past(red_cnt_q) >= 9'(RED_MS) && $past(rx_i.basic_frame_loss);
	endproperty
	a_red_set: assert property (p_red_set) else $error("red alarm raised too early");

	property p_sec_step;
		@(posedge clk_sys_i) disable iff (rst_i)
		$changed(one_second_toggle_q) |-> $changed(half_second_toggle_q);
	endproperty
	a_sec_step: assert property (p_sec_step) else $error("second timers out of step");

	sequence s_fas_taken;
		rx_i.fas_strobe ##1 1'b1;
	endsequence
	property p_fas_capture;
		@(posedge clk_sys_i) disable iff (rst_i)
		s_fas_taken |-> fas_q == $past(rx_i.fas_byte);
	endproperty
	a_fas_capture: assert property (p_fas_capture) else $error("alignment byte not captured");

	property p_short_toggle;
		@(posedge clk_sys_i) disable iff (rst_i)
		$rose(crc4_search_timeout_q) |-> $changed(short_crc_timer_toggle_q);
	endproperty
	a_short_toggle: assert property (p_short_toggle) else $error("short toggle missed");

	property p_reframe;
		@(posedge clk_sys_i) disable iff (rst_i)
		reframe_q |-> $rose(crc4_search_timeout_q) && $past(rx_i.maint_option)
			&& !$past(rx_i.auto_interwork) ##1 !reframe_q;
	endproperty
	a_reframe: assert property (p_reframe) else $error("reframe request wrong");

	property p_keep_clear;
		@(posedge clk_sys_i) disable iff (rst_i)
		!rx_i.all_ones_alarm_status |=> !keep_alive_flag_q;
	endproperty
	a_keep_clear: assert property (p_keep_clear) else $error("keep-alive held");

	property p_t2_clears_t1;
		@(posedge clk_sys_i) disable iff (rst_i)
		terminal_sync_persist_flag_q |=> !nonnormal_persist_flag_q;
	endproperty
	a_t2_clears_t1: assert property (p_t2_clears_t1) else $error("flag one not cleared");

	property p_unused_read;
		@(posedge clk_sys_i) disable iff (rst_i)
		rd_act && page_hit && rd_addr > OFS_SPARE && rd_addr < OFS_IDENT
			|=> data_o == UNUSED_READ && data_oe_o;
	endproperty
	a_unused_read: assert property (p_unused_read) else $error("unused address not zero");

	property p_no_drive_on_write;
		@(posedge clk_sys_i) disable iff (rst_i)
		!rd_act |=> !data_oe_o;
	endproperty
	a_no_drive_on_write: assert property (p_no_drive_on_write) else $error("bus driven");
endmodule

/* rtl/e1rs_tick_div.sv */
// Divider that yields a one-cycle enable pulse every CYCLES clocks
`timescale 1ns/10ps
module e1rs_tick_div #(
	parameter int unsigned CYCLES = 40000
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Enable pulse
	output logic tick_o
);
	logic [15:0] cnt_q;
	logic wrap;

	assign wrap = (cnt_q == 16'(CYCLES - 1));

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cnt_q <= 16'h0000;
			tick_o <= 1'b0;
		end else begin
			cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
			tick_o <= wrap;
		end
	end
endmodule
